// ### src/igp_bridge.sv
// Request FIFO and top level of the I/O-mapped graphics processor access bridge
`timescale 1ns/100ps

// ********************************
// Request FIFO
// ********************************
module igp_fifo
  import igp_pkg::*;
#(
  parameter int W = 46,
  parameter int DEPTH = 16
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (ce_in && push)
    begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ********************************
// Bridge top level
// ********************************
module igp_bridge
  import igp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic isa_sel_n_in,
  input wire logic isa_ior_n_in,
  input wire logic isa_iow_n_in,
  input wire logic [IDX_W-1:0] isa_idx_in,
  input wire logic [DW-1:0] isa_data_in,
  output logic [DW-1:0] isa_data_out,
  output logic isa_data_oe_out,
  output logic isa_chrdy_oe_out,
  input wire logic local_clock_one_in,
  input wire logic gp_ready_in,
  input wire logic gp_irq_out_in,
  input wire logic rom_window_strap_in,
  input wire logic narrow_size_indication_in,
  input wire logic [GP_DW-1:0] gp_data_in,
  output logic [PTR_W-2:0] gp_host_address_lines_out,
  output logic word_half_select_out,
  output logic gp_host_select_out,
  output logic gp_write_out,
  output logic [GP_DW-1:0] gp_data_out,
  output logic gp_data_oe_out,
  input wire logic [3:0] window_hit_in,
  output logic [3:0] window_enables_out,
  output logic wide_memory_response_out,
  output logic port_path_enable_out,
  output logic palette_read_enable_out,
  output logic palette_write_enable_out,
  output logic lane_swap_lower_out,
  output logic extension_off_out,
  output logic [DW-EXT_LO-1:0] ext_map_out,
  output logic reset_n_out
);
  igp_isa_t isa_s1_q;
  igp_isa_t isa_s2_q;
  igp_gp_t gp_s1_q;
  igp_gp_t gp_s2_q;
  logic ior_prev_q;
  logic iow_prev_q;
  logic lclk_prev_q;
  logic start_rd;
  logic start_wr;
  logic lclk_rise;
  logic [PTR_W-1:0] ptr_q;
  logic [15:0] mode_q;
  logic [15:0] ext_q;
  logic [3:0] bank_idx_q;
  logic [DW-1:0] bank_mem_q [16];
  logic [2:0] sr_cnt_q;
  logic rst;
  logic pend_q;
  igp_req_t pend_ent_q;
  igp_req_t ent;
  logic ent_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  igp_req_t fifo_out;
  logic rd_wait_q;
  logic rd_done_q;
  logic [DW-1:0] rd_data_q;
  logic [DW-1:0] reg_view;
  igp_state_t st_q;

  // ********************************
  // Pin synchronisers
  // ********************************
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
    begin
      isa_s1_q <= '{isa_sel_n_in, isa_ior_n_in, isa_iow_n_in, isa_idx_in, isa_data_in};
      isa_s2_q <= isa_s1_q;
      gp_s1_q <= '{local_clock_one_in, gp_ready_in, gp_irq_out_in, rom_window_strap_in,
                   narrow_size_indication_in, gp_data_in};
      gp_s2_q <= gp_s1_q;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ior_prev_q <= 1'b1;
      iow_prev_q <= 1'b1;
      lclk_prev_q <= 1'b0;
    end
    else if (ce_in)
    begin
      ior_prev_q <= isa_s2_q.ior_n | isa_s2_q.sel_n;
      iow_prev_q <= isa_s2_q.iow_n | isa_s2_q.sel_n;
      lclk_prev_q <= gp_s2_q.lclk;
    end
  end

  assign start_rd = ior_prev_q & ~(isa_s2_q.ior_n | isa_s2_q.sel_n);
  assign start_wr = iow_prev_q & ~(isa_s2_q.iow_n | isa_s2_q.sel_n);
  assign lclk_rise = gp_s2_q.lclk & ~lclk_prev_q;

  // ********************************
  // Self reset
  // ********************************
  // Counter is cleared only by the external reset so the pulse survives itself
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sr_cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (start_wr && isa_s2_q.idx == IDX_MODE && isa_s2_q.data[MB_SELF_RST])
      begin
        // Spare count: a local clock edge may already sit in the synchroniser
        sr_cnt_q <= SR_LCLK_MIN + 3'h1;
      end
      else if (sr_cnt_q != '0 && lclk_rise)
      begin
        sr_cnt_q <= sr_cnt_q - 1'b1;
      end
    end
  end

  assign rst = reset_in | (sr_cnt_q != '0);

  // ********************************
  // Configuration registers
  // ********************************
  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      mode_q <= MODE_RESET;
      mode_q[MB_WIN_LO+3] <= gp_s2_q.strap;
      ext_q <= EXT_RESET;
      bank_idx_q <= '0;
    end
    else if (ce_in && (start_wr || start_rd))
    begin
      if (start_wr && isa_s2_q.idx == IDX_MODE)
      begin
        mode_q <= isa_s2_q.data;
        mode_q[MB_SELF_RST] <= 1'b0;
      end
      if (start_wr && isa_s2_q.idx == IDX_MAPEXT)
      begin
        ext_q[15:EXT_LO] <= isa_s2_q.data[15:EXT_LO];
        ext_q[EXT_OFF_BIT] <= isa_s2_q.data[EXT_OFF_BIT];
      end
      if (start_wr && isa_s2_q.idx == IDX_BANK_CTL)
      begin
        bank_idx_q <= isa_s2_q.data[BANK_IDX_LO+:4];
      end
      if (isa_s2_q.idx == IDX_BANK_PORT)
      begin
        bank_idx_q <= bank_idx_q + 1'b1;
      end
    end
  end

  // Entries 0..7 hold address halves, 8..15 mask halves
  always_ff @(posedge clk_in)
  begin
    if (ce_in && start_wr && isa_s2_q.idx == IDX_BANK_PORT)
    begin
      bank_mem_q[bank_idx_q] <= isa_s2_q.data;
    end
  end

  // ********************************
  // Address pointer
  // ********************************
  // Pointer is advanced when the access is taken (word reads only with follow clear), so readback already
  // shows the next address even while the request still sits queued
  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      ptr_q <= '0;
    end
    else if (ce_in)
    begin
      if (start_wr && isa_s2_q.idx == IDX_PTR_LO)
      begin
        ptr_q[15:0] <= isa_s2_q.data;
      end
      else if (start_wr && isa_s2_q.idx == IDX_PTR_HI)
      begin
        ptr_q[PTR_W-1:16] <= isa_s2_q.data[PTR_W-17:0];
      end
      else if (start_wr && isa_s2_q.idx == IDX_WORD)
      begin
        ptr_q <= ptr_q + 1'b1;
      end
      else if (start_rd && isa_s2_q.idx == IDX_WORD && !mode_q[MB_FOLLOW])
      begin
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // ********************************
  // Request formation and queueing
  // ********************************
  always_comb
  begin
    ent_valid = 1'b0;
    ent = '{K_REL, ptr_q, isa_s2_q.data};
    if ((start_rd || start_wr) && mode_q[MB_PORT_EN])
    begin
      if (isa_s2_q.idx == IDX_WORD)
      begin
        ent_valid = 1'b1;
        ent.kind = start_wr ? K_WR : K_RD;
      end
      else if (isa_s2_q.idx == IDX_PTR_LO || isa_s2_q.idx == IDX_PTR_HI)
      begin
        ent_valid = 1'b1;
      end
    end
  end

  // A refused push parks here while the host is held off
  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      pend_ent_q <= '{K_REL, '0, '0};
    end
    else if (ce_in)
    begin
      if (ent_valid && !fifo_in_ready)
      begin
        pend_q <= 1'b1;
        pend_ent_q <= ent;
      end
      else if (pend_q && fifo_in_ready)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  igp_fifo #(.W($bits(igp_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_in(rst),
    .ce_in(ce_in),
    .in_valid_in(pend_q | ent_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(pend_q ? pend_ent_q : ent),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out)
  );

  // ********************************
  // Graphics processor host cycles
  // ********************************
  assign fifo_out_ready = (st_q == ST_IDLE) && lclk_rise;

  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      gp_host_select_out <= 1'b0;
      gp_write_out <= 1'b0;
      gp_data_oe_out <= 1'b0;
      gp_host_address_lines_out <= '0;
      word_half_select_out <= 1'b0;
      gp_data_out <= '0;
      rd_done_q <= 1'b0;
      rd_data_q <= '0;
    end
    else if (ce_in)
    begin
      rd_done_q <= 1'b0;
      unique case (st_q)
        ST_IDLE:
        begin
          if (fifo_out_valid && lclk_rise)
          begin
            if (fifo_out.kind == K_REL)
            begin
              gp_host_select_out <= 1'b0;
            end
            else
            begin
              gp_host_address_lines_out <= fifo_out.addr[PTR_W-1:1];
              word_half_select_out <= fifo_out.addr[0];
              gp_host_select_out <= 1'b1;
              gp_write_out <= (fifo_out.kind == K_WR);
              gp_data_oe_out <= (fifo_out.kind == K_WR);
              gp_data_out <= {fifo_out.data, fifo_out.data};
              st_q <= ST_BUSY;
            end
          end
        end
        ST_BUSY:
        begin
          if (lclk_rise && gp_s2_q.ready)
          begin
            if (!gp_write_out)
            begin
              rd_data_q <= word_half_select_out ? gp_s2_q.data[31:16]
                                                : gp_s2_q.data[15:0];
              rd_done_q <= 1'b1;
            end
            gp_data_oe_out <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ********************************
  // ISA read data and channel ready
  // ********************************
  always_comb
  begin
    reg_view = '0;
    unique case (isa_s2_q.idx)
      IDX_PTR_LO: reg_view = ptr_q[15:0];
      IDX_PTR_HI: reg_view = {{(32-PTR_W){1'b0}}, ptr_q[PTR_W-1:16]};
      IDX_MODE: reg_view = {mode_q[15:7], gp_s2_q.irq, mode_q[5], 1'b0, mode_q[3:0]};
      IDX_MAPEXT: reg_view = {ext_q[15:EXT_LO], 3'h0, ext_q[EXT_OFF_BIT]};
      IDX_BANK_CTL: reg_view = {11'h000, bank_idx_q, 1'b0};
      IDX_BANK_PORT: reg_view = bank_mem_q[bank_idx_q];
      default: reg_view = '0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      rd_wait_q <= 1'b0;
      isa_data_out <= '0;
      isa_data_oe_out <= 1'b0;
      isa_chrdy_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start_rd && isa_s2_q.idx == IDX_WORD && mode_q[MB_PORT_EN])
      begin
        rd_wait_q <= 1'b1;
      end
      else if (rd_done_q)
      begin
        rd_wait_q <= 1'b0;
        isa_data_out <= rd_data_q;
      end
      if (start_rd && !(isa_s2_q.idx == IDX_WORD && mode_q[MB_PORT_EN]))
      begin
        isa_data_out <= reg_view;
      end
      isa_data_oe_out <= ~(isa_s2_q.ior_n | isa_s2_q.sel_n);
      isa_chrdy_oe_out <= rd_wait_q | pend_q | (ent_valid && !fifo_in_ready);
    end
  end

  // ********************************
  // Decode-facing outputs
  // ********************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      window_enables_out <= '0;
      wide_memory_response_out <= 1'b0;
      port_path_enable_out <= 1'b0;
      palette_read_enable_out <= 1'b0;
      palette_write_enable_out <= 1'b1;
      lane_swap_lower_out <= 1'b0;
      extension_off_out <= 1'b1;
      ext_map_out <= '0;
      reset_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      window_enables_out <= mode_q[MB_PORT_EN] ? 4'h0 : mode_q[MB_WIN_LO+:4];
      wide_memory_response_out <= !mode_q[MB_WIDE_PROBE] && !mode_q[MB_PORT_EN]
        && |(window_hit_in & mode_q[MB_WIDE_LO+:4] & mode_q[MB_WIN_LO+:4]);
      port_path_enable_out <= mode_q[MB_PORT_EN];
      palette_read_enable_out <= mode_q[MB_PAL_RD] & ~mode_q[MB_PAL_DIS];
      palette_write_enable_out <= ~mode_q[MB_PAL_DIS];
      lane_swap_lower_out <= gp_s2_q.narrow_size_indication & mode_q[MB_LANE];
      extension_off_out <= ext_q[EXT_OFF_BIT];
      ext_map_out <= ext_q[15:EXT_LO];
      reset_n_out <= (sr_cnt_q == '0);
    end
  end
endmodule

// ### src/igp_pkg.sv
// Constants and carrier types for the ISA I/O-mapped graphics processor access bridge
package igp_pkg;
  localparam int IDX_W = 4;
  localparam int DW = 16;
  localparam int PTR_W = 28;
  localparam int GP_DW = 32;
  // Register indices within the 16-entry I/O block
  localparam logic [3:0] IDX_PTR_LO = 4'h0;
  localparam logic [3:0] IDX_PTR_HI = 4'h1;
  localparam logic [3:0] IDX_WORD = 4'h2;
  localparam logic [3:0] IDX_MODE = 4'h3;
  localparam logic [3:0] IDX_MAPEXT = 4'h4;
  localparam logic [3:0] IDX_BANK_CTL = 4'h5;
  localparam logic [3:0] IDX_BANK_PORT = 4'h6;
  // Mode control field positions
  localparam int MB_WIDE_PROBE = 15;
  localparam int MB_PAL_RD = 14;
  localparam int MB_FOLLOW = 13;
  localparam int MB_LANE = 12;
  localparam int MB_PORT_EN = 11;
  localparam int MB_WIDE_LO = 7;
  localparam int MB_IRQ = 6;
  localparam int MB_PAL_DIS = 5;
  localparam int MB_SELF_RST = 4;
  localparam int MB_WIN_LO = 0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // Map extension field positions
  localparam int EXT_LO = 4;
  localparam int EXT_OFF_BIT = 0;
  localparam logic [15:0] EXT_RESET = 16'h0001;
  // Bank control index field position
  localparam int BANK_IDX_LO = 1;
  // Self reset length in local clock cycles
  localparam logic [2:0] SR_LCLK_MIN = 3'h4;

  typedef enum logic [1:0] {K_WR = 2'h0, K_RD = 2'h1, K_REL = 2'h2} igp_kind_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} igp_state_t;

  typedef struct packed {
    igp_kind_t kind;
    logic [PTR_W-1:0] addr;
    logic [DW-1:0] data;
  } igp_req_t;

  typedef struct packed {
    logic sel_n;
    logic ior_n;
    logic iow_n;
    logic [IDX_W-1:0] idx;
    logic [DW-1:0] data;
  } igp_isa_t;

  typedef struct packed {
    logic lclk;
    logic ready;
    logic irq;
    logic strap;
    logic narrow_size_indication;
    logic [GP_DW-1:0] data;
  } igp_gp_t;
endpackage

// ### tb/igp_gp_model.sv
// Behavioural model of the processor host interface and its local clock
`timescale 1ns/100ps
module igp_gp_model
  import igp_pkg::*;
(
  input wire logic [1:0] wait_in,
  input wire logic irq_in,
  input wire logic [PTR_W-2:0] addr_in,
  input wire logic half_in,
  input wire logic sel_in,
  input wire logic wr_in,
  input wire logic oe_in,
  input wire logic [GP_DW-1:0] data_in,
  output logic lclk_out = 1'h0,
  output logic ready_out = 1'h0,
  output logic irq_out,
  output logic [GP_DW-1:0] data_out = 32'h0
);
  logic [GP_DW-1:0] mem [16];
  logic [1:0] cnt = 2'h0;
  logic [3:0] ix;
  // Local clock runs free, as the processor keeps it going
  initial
    forever #80 lclk_out = ~lclk_out;
  assign irq_out = irq_in;
  // Top pointer bits fold into the index so a lost upper half shows up
  assign ix = addr_in[3:0] ^ addr_in[26:23];
  // Processor indexes its memory with the bridge pointer address on every host cycle
  always @(posedge lclk_out)
  begin
    ready_out <= sel_in && cnt == wait_in;
    cnt <= (sel_in && cnt != wait_in) ? cnt + 2'h1 : 2'h0;
    if (sel_in && wr_in && oe_in && half_in)
      mem[ix][31:16] <= data_in[31:16];
    if (sel_in && wr_in && oe_in && !half_in)
      mem[ix][15:0] <= data_in[15:0];
    // Released bus never repeats a stale value
    data_out <= (sel_in && !wr_in) ? mem[ix] : ~data_out;
  end
endmodule

// ### tb/igp_checker.sv
// Concurrent property checker for the I/O-mapped processor access bridge
`timescale 1ns/100ps
module igp_checker
  import igp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic isa_sel_n_in,
  input wire logic isa_ior_n_in,
  input wire logic isa_iow_n_in,
  input wire logic [IDX_W-1:0] isa_idx_in,
  input wire logic [DW-1:0] isa_data_in,
  input wire logic isa_chrdy_oe_out,
  input wire logic gp_host_select_out,
  input wire logic gp_write_out,
  input wire logic gp_data_oe_out,
  input wire logic [3:0] window_enables_out,
  input wire logic wide_memory_response_out,
  input wire logic port_path_enable_out,
  input wire logic palette_read_enable_out,
  input wire logic palette_write_enable_out,
  input wire logic extension_off_out,
  input wire logic reset_n_out
);
  // ****************
  // Bus sequences
  // ****************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  sequence ptr_acc;
    $fell(isa_iow_n_in) && !isa_sel_n_in && isa_idx_in <= IDX_PTR_HI && port_path_enable_out;
  endsequence
  sequence word_rd;
    $fell(isa_ior_n_in) && !isa_sel_n_in && isa_idx_in == IDX_WORD && port_path_enable_out;
  endsequence
  sequence self_rst_wr;
    $fell(isa_iow_n_in) && !isa_sel_n_in && isa_idx_in == IDX_MODE && isa_data_in[MB_SELF_RST];
  endsequence
  // ****************
  // Properties
  // ****************
  palette_gate_a: assert property (palette_read_enable_out |-> palette_write_enable_out)
    else $error("palette read enabled while palette disabled");
  port_excl_a: assert property (port_path_enable_out |-> window_enables_out == 4'h0)
    else $error("memory window enabled beside port path");
  wide_gate_a: assert property (wide_memory_response_out |-> !port_path_enable_out)
    else $error("wide response while port path enabled");
  reset_vals_a: assert property ($past(reset_in) |-> palette_write_enable_out
    && extension_off_out && reset_n_out && !port_path_enable_out)
    else $error("wrong output levels after reset");
  ptr_release_a: assert property (ptr_acc |-> ##[1:400] !gp_host_select_out)
    else $error("host select not released by pointer access");
  word_wait_a: assert property (word_rd |-> ##[2:8] isa_chrdy_oe_out)
    else $error("word port read not extended");
  wdata_qual_a: assert property (gp_data_oe_out |-> gp_write_out && gp_host_select_out)
    else $error("write data driven outside a selected write");
  self_rst_go_a: assert property (self_rst_wr |-> ##[1:60] !reset_n_out)
    else $error("self reset not started");
  self_rst_len_a: assert property ($fell(reset_n_out) |-> !reset_n_out [*8])
    else $error("self reset output too short");
endmodule
bind igp_bridge igp_checker i_igp_checker (.clk_in, .reset_in, .isa_sel_n_in, .isa_ior_n_in,
  .isa_iow_n_in, .isa_idx_in, .isa_data_in, .isa_chrdy_oe_out, .gp_host_select_out,
  .gp_write_out, .gp_data_oe_out, .window_enables_out, .wide_memory_response_out,
  .port_path_enable_out, .palette_read_enable_out, .palette_write_enable_out,
  .extension_off_out, .reset_n_out);

// ### tb/igp_bridge_test.sv
// Self-checking bench for the I/O-mapped processor access bridge
`timescale 1ns/100ps
module igp_bridge_test;
  import igp_pkg::*;
  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [15:0] d;
    logic [3:0] hit;
    logic nar;
    logic [8:0] o;
  } igp_row_t;
  logic clk, rst, sel_n, ior_n, iow_n, nar, irq, doe, chrdy, lclk, rdy, gpirq, strap;
  logic half, hsel, gwr, goe, wide, port, prd, pwr, lane, xoff, rstn;
  logic [1:0] wt;
  logic [3:0] idx, hit, win;
  logic [15:0] din, dout, rd;
  logic [GP_DW-1:0] gdin, gdout;
  logic [PTR_W-2:0] haddr;
  logic [11:0] xmap;
  int n_mismatch, samples_checked, i, n;
  // Outputs column: lane, wide, palette read, palette write, port path, windows
  igp_row_t rows [10] = '{
    '{1'h0, IDX_MODE, 16'h0008, 4'h0, 1'h0, 9'h028}, '{1'h1, IDX_MODE, 16'h4000, 4'h0, 1'h0, 9'h060},
    '{1'h1, IDX_MODE, 16'h4020, 4'h0, 1'h0, 9'h000}, '{1'h1, IDX_MODE, 16'h108F, 4'h1, 1'h1, 9'h1AF},
    '{1'h0, IDX_MODE, 16'h108F, 4'h2, 1'h0, 9'h02F}, '{1'h1, IDX_MODE, 16'h808F, 4'h1, 1'h0, 9'h02F},
    '{1'h1, IDX_MAPEXT, 16'h5A30, 4'h0, 1'h0, 9'h02F}, '{1'h0, IDX_MAPEXT, 16'h5A30, 4'h0, 1'h0, 9'h02F},
    '{1'h0, 4'h9, 16'h0000, 4'h0, 1'h0, 9'h02F}, '{1'h1, IDX_MODE, 16'h088F, 4'h1, 1'h0, 9'h030}};

  igp_bridge i_igp_bridge (.clk_in(clk), .reset_in(rst), .ce_in(1'h1), .isa_sel_n_in(sel_n),
    .isa_ior_n_in(ior_n), .isa_iow_n_in(iow_n), .isa_idx_in(idx), .isa_data_in(din),
    .isa_data_out(dout), .isa_data_oe_out(doe), .isa_chrdy_oe_out(chrdy),
    .local_clock_one_in(lclk), .gp_ready_in(rdy), .gp_irq_out_in(gpirq),
    .rom_window_strap_in(strap), .narrow_size_indication_in(nar), .gp_data_in(gdin),
    .gp_host_address_lines_out(haddr), .word_half_select_out(half), .gp_host_select_out(hsel),
    .gp_write_out(gwr), .gp_data_out(gdout), .gp_data_oe_out(goe), .window_hit_in(hit),
    .window_enables_out(win), .wide_memory_response_out(wide), .port_path_enable_out(port),
    .palette_read_enable_out(prd), .palette_write_enable_out(pwr), .lane_swap_lower_out(lane),
    .extension_off_out(xoff), .ext_map_out(xmap), .reset_n_out(rstn));
  igp_gp_model i_igp_gp_model (.wait_in(wt), .irq_in(irq), .addr_in(haddr), .half_in(half),
    .sel_in(hsel), .wr_in(gwr), .oe_in(goe), .data_in(gdout), .lclk_out(lclk),
    .ready_out(rdy), .irq_out(gpirq), .data_out(gdin));

  // ****************
  // Tasks
  // ****************
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // One ISA I/O cycle; the strobe stays low while the bridge extends it
  task automatic acc(input logic w, input logic [3:0] x, input logic [15:0] d);
    int k;
    @(posedge clk);
    #1;
    sel_n = 1'h0;
    idx = x;
    din = d;
    iow_n = !w;
    ior_n = w;
    idle(6);
    k = 0;
    while (chrdy === 1'h1 && k < 3000)
    begin
      #5;
      k++;
    end
    n_mismatch += int'(k >= 3000);
    #5;
    rd = dout;
    check("data oe", {31'h0, doe}, {31'h0, !w});
    sel_n = 1'h1;
    ior_n = 1'h1;
    iow_n = 1'h1;
    idle(4);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #250000;
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    {rst, sel_n, ior_n, iow_n, strap} = 5'h1F;
    {idx, din, hit, nar, irq, wt} = 28'h1;
    n_mismatch = 0;
    samples_checked = 0;
    idle(8);
    rst = 1'h0;
    for (i = 0; i < 10; i++)
    begin
      hit = rows[i].hit;
      nar = rows[i].nar;
      acc(rows[i].wr, rows[i].idx, rows[i].d);
      if (!rows[i].wr) check("reg read", 32'(rd), 32'(rows[i].d));
      check("cfg outs", {23'h0, lane, wide, prd, pwr, port, win}, {23'h0, rows[i].o});
      $display("row %0d done", i);
    end
    check("extension", {19'h0, xoff, xmap}, 32'h05A3);
    irq = 1'h1;
    acc(1'h0, IDX_MODE, 16'h0);
    check("irq view", 32'(rd), 32'h08CF);
    irq = 1'h0;
    acc(1'h1, IDX_PTR_HI, 16'h0ABC);
    acc(1'h1, IDX_PTR_LO, 16'h0010);
    acc(1'h1, IDX_WORD, 16'h1234);
    acc(1'h1, IDX_WORD, 16'h5678);
    acc(1'h0, IDX_PTR_LO, 16'h0);
    check("ptr next", 32'(rd), 32'h0012);
    acc(1'h1, IDX_PTR_LO, 16'h0010);
    idle(400);
    check("sel release", {31'h0, hsel}, 32'h0);
    wt = 2'h3;
    acc(1'h0, IDX_WORD, 16'h0);
    check("word rd0", 32'(rd), 32'h1234);
    acc(1'h0, IDX_WORD, 16'h0);
    check("word rd1", 32'(rd), 32'h5678);
    check("gp addr", {4'h0, haddr, half}, 32'h0ABC0011);
    $display("word port done");
    acc(1'h1, IDX_MODE, 16'h2800);
    acc(1'h1, IDX_PTR_LO, 16'h0010);
    acc(1'h0, IDX_WORD, 16'h0);
    acc(1'h0, IDX_PTR_LO, 16'h0);
    check("ptr hold", 32'(rd), 32'h0010);
    // Far side is slow, so the queue fills; refused pushes park and the ISA cycle is held until space frees
    for (i = 0; i < 18; i++)
      acc(1'h1, IDX_WORD, 16'(i));
    idle(2500);
    acc(1'h0, IDX_PTR_LO, 16'h0);
    check("ptr after burst", 32'(rd), 32'h0022);
    $display("follow write done");
    acc(1'h1, IDX_BANK_CTL, 16'h000E);
    for (i = 0; i < 3; i++)
      acc(1'h1, IDX_BANK_PORT, 16'hB000 + 16'(i));
    acc(1'h1, IDX_BANK_CTL, 16'h000E);
    for (i = 0; i < 3; i++)
    begin
      acc(1'h0, IDX_BANK_PORT, 16'h0);
      check("bank port", 32'(rd), 32'hB000 + 32'(i));
    end
    $display("bank port done");
    fork
      acc(1'h1, IDX_MODE, 16'h0010);
      begin
        @(negedge rstn);
        n = 0;
        while (rstn !== 1'h1 && n < 40)
        begin
          @(posedge lclk or posedge rstn);
          n += int'(rstn === 1'h0);
        end
      end
    join
    check("self reset", 32'(n >= 4), 32'h1);
    acc(1'h0, IDX_MODE, 16'h0);
    check("mode after self reset", {15'h0, xoff, rd}, 32'h10008);
    acc(1'h1, IDX_WORD, 16'h1111);
    idle(100);
    check("port off", {31'h0, hsel}, 32'h0);
    $display("self reset done");
    acc(1'h1, IDX_MODE, 16'h4800);
    rst = 1'h1;
    strap = 1'h0;
    idle(8);
    rst = 1'h0;
    idle(1);
    check("reset outs", {27'h0, prd, pwr, port, xoff, rstn}, 32'h0B);
    acc(1'h0, IDX_MODE, 16'h0);
    check("mode reset", 32'(rd), 32'h0000);
    $display("reset done");
    end_sim;
  end
endmodule
